// ===== hw/sps_lock_detect.sv
// lock detector: flags lock once the raw lock holds for the programmed count
`default_nettype none
module sps_lock_detect
   import sps_pkg::*;
#(
   parameter int CNT_W = sps_pkg::LOCK_CNT_W
)
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             enable,
   input  wire logic             lock_raw,
   input  wire logic [CNT_W-1:0] lock_count,
   output logic                  locked_ff
);

   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic             nxt_locked;
   wire              reached = (cnt_ff >= lock_count);

   // count consecutive locked cycles, clear on any loss of lock
   assign nxt_cnt    = (!enable || !lock_raw) ? '0 :
                       reached ? cnt_ff : cnt_ff + 1'b1;
   assign nxt_locked = enable && lock_raw && reached;

   // state registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_ff    <= '0;
         locked_ff <= 1'b0;
      end
      else
      begin
         cnt_ff    <= nxt_cnt;
         locked_ff <= nxt_locked;
      end
   end

endmodule
`default_nettype wire

// ===== hw/sps_pkg.sv
// constants for the serdes pll status and configuration register bank
`default_nettype none
package sps_pkg;

   // ==========================================================
   // register access port
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;

   // ==========================================================
   // register offsets
   localparam logic [11:0] OFS_STATUS  = 12'h281;
   localparam logic [11:0] OFS_LOOP_A  = 12'h284;
   localparam logic [11:0] OFS_LOOP_B  = 12'h285;
   localparam logic [11:0] OFS_LOOP_C  = 12'h286;
   localparam logic [11:0] OFS_PUMP    = 12'h287;
   localparam logic [11:0] OFS_REFDIV  = 12'h289;

   // ==========================================================
   // status bit positions
   localparam int ST_LOCK    = 0;
   localparam int ST_BIAS    = 1;
   localparam int ST_VCOCAL  = 2;
   localparam int ST_CPVALID = 3;
   localparam int ST_CPLOW   = 4;
   localparam int ST_CPHIGH  = 5;

   // ==========================================================
   // field positions
   localparam int LF_HI_MSB   = 7;
   localparam int LF_HI_LSB   = 4;
   localparam int LF_LO_MSB   = 3;
   localparam int LF_LO_LSB   = 0;
   localparam int PUMP_CUR_MSB = 5;
   localparam int PUMP_MODE    = 6;
   localparam int REF_SEL      = 3;
   localparam int REF_BYPASS   = 2;
   localparam int OVS_MSB      = 1;

   // ==========================================================
   // reset values
   localparam logic [7:0] RST_STATUS = 8'h00;
   localparam logic [7:0] RST_LOOP_A = 8'h77;
   localparam logic [7:0] RST_LOOP_B = 8'h87;
   localparam logic [7:0] RST_LOOP_C = 8'h08;
   localparam logic [7:0] RST_PUMP   = 8'h3f;
   localparam logic [7:0] RST_REFDIV = 8'h04;

   // ==========================================================
   // oversampling codes
   localparam logic [1:0] OVS_NONE = 2'h0;
   localparam logic [1:0] OVS_X2   = 2'h1;
   localparam logic [1:0] OVS_X4   = 2'h2;

   // ==========================================================
   // lock detect counter width
   localparam int LOCK_CNT_W = 16;

   // power-up and calibration sequencer states
   typedef enum logic [1:0] {SPS_IDLE, SPS_POWER, SPS_CAL, SPS_RUN} sps_seq_e;

endpackage
`default_nettype wire

// ===== hw/sps_regs.sv
// serdes pll status readback and configuration register bank
//
// Contract
// - status bit 0 is set after lock held for the lock-detect count
// - status bit 2 reads 1 while oscillator calibration runs
// - status bit 3 reads 1 once pump calibration is valid
// - with output level zero, bit 5 flags pump above high threshold
// - with output level zero, bit 4 flags pump below low threshold
// - status bit 1 reads 1 when bias currents are ready
// - status is read-only, resets to zero, bits 7:6 read zero
// - three loop filter registers, two 4-bit fields, resets 77 87 08
// - regulator reference select bit 3, 0 band gap, resets 0
// - bit 2 bypasses regulator reference filter, resets 1
// - 2-bit oversampling field bits 1:0, resets zero
// - oversampling codes: 0 none, 1 two times, 2 four times
// - synth enable turns on currents then starts calibration
`default_nettype none
module sps_regs
   import sps_pkg::*;
(
   // ==========================================================
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst_n,

   // ==========================================================
   // register access port from the serial control engine
   input  wire logic [sps_pkg::ADDR_W-1:0]    reg_addr,
   input  wire logic                          reg_wr_en,
   input  wire logic [sps_pkg::DATA_W-1:0]    reg_wr_data,
   input  wire logic                          reg_rd_en,
   output logic      [sps_pkg::DATA_W-1:0]    reg_rd_data_ff,
   output logic                               reg_rd_valid_ff,

   // ==========================================================
   // controls held in neighbouring registers
   input  wire logic                          synth_enable,
   input  wire logic                          recal_request,
   input  wire logic [sps_pkg::LOCK_CNT_W-1:0] lock_detect_count,
   input  wire logic [3:0]                    oscillator_output_level,

   // ==========================================================
   // live indications from the analog pll
   input  wire logic                          pll_lock_raw,
   input  wire logic                          bias_currents_ready,
   input  wire logic                          oscillator_calibration_running,
   input  wire logic                          pump_calibration_valid,
   input  wire logic                          pump_above_high_threshold,
   input  wire logic                          pump_below_low_threshold,

   // ==========================================================
   // settings and sequencing outputs to the analog pll
   output logic      [7:0]                    loop_filter_a_ff,
   output logic      [7:0]                    loop_filter_b_ff,
   output logic      [7:0]                    loop_filter_c_ff,
   output logic      [5:0]                    pump_current_setting_ff,
   output logic                               logic_generator_power_mode_ff,
   output logic                               regulator_reference_select_ff,
   output logic                               regulator_filter_bypass_ff,
   output logic      [1:0]                    input_oversample_select_ff,
   output logic                               synth_locked_flag_ff,
   output logic                               pll_currents_on_ff,
   output logic                               pll_cal_start_ff
);

   // ==========================================================
   // address decode

   // single-address match, used for every register; a full 12-bit
   // compare, so no alias of the map ever selects a register
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   wire sel_status = hit(reg_addr, OFS_STATUS);
   wire sel_loop_a = hit(reg_addr, OFS_LOOP_A);
   wire sel_loop_b = hit(reg_addr, OFS_LOOP_B);
   wire sel_loop_c = hit(reg_addr, OFS_LOOP_C);
   wire sel_pump   = hit(reg_addr, OFS_PUMP);
   wire sel_refdiv = hit(reg_addr, OFS_REFDIV);

   // write strobes; the status register takes no writes, and a write to
   // an unmapped address is dropped without any indication
   wire wr_loop_a = reg_wr_en && sel_loop_a;
   wire wr_loop_b = reg_wr_en && sel_loop_b;
   wire wr_loop_c = reg_wr_en && sel_loop_c;
   wire wr_pump   = reg_wr_en && sel_pump;
   wire wr_refdiv = reg_wr_en && sel_refdiv;

   // ==========================================================
   // power-up sequencing and lock detection

   logic lock_flag;

   // enable brings currents up, then the sequencer starts calibration;
   // the first start waits for bias ready; a recal request in run restarts calibration without checking bias ready
   sps_sequencer sps_sequencer_i (
      .clk            (clk),
      .rst_n          (rst_n),
      .synth_enable   (synth_enable),
      .recal_request  (recal_request),
      .bias_ready     (bias_currents_ready),
      .currents_on_ff (pll_currents_on_ff),
      .cal_start_ff   (pll_cal_start_ff)
   );

   // lock must hold for the programmed count before it is reported;
   // any drop of raw lock restarts the count, so a brief lock is not shown
   sps_lock_detect #(
      .CNT_W (LOCK_CNT_W)
   ) sps_lock_detect_i (
      .clk        (clk),
      .rst_n      (rst_n),
      .enable     (synth_enable),
      .lock_raw   (pll_lock_raw),
      .lock_count (lock_detect_count),
      .locked_ff  (lock_flag)
   );

   // ==========================================================
   // live status image
   // status bits follow the analog pll one cycle late; reads never stall

   logic [7:0] status_ff;
   logic [7:0] nxt_status;

   // range flags only mean something at output level zero; at any other
   // level the comparators are not meaningful and their bits read zero
   wire level_zero = (oscillator_output_level == 4'h0);
   wire range_high = level_zero && pump_above_high_threshold;
   wire range_low  = level_zero && pump_below_low_threshold;

   // status bits in register order, reserved bits held at reset value
   always_comb
   begin
      nxt_status             = RST_STATUS;
      nxt_status[ST_LOCK]    = lock_flag;
      nxt_status[ST_BIAS]    = bias_currents_ready;
      nxt_status[ST_VCOCAL]  = oscillator_calibration_running;
      nxt_status[ST_CPVALID] = pump_calibration_valid;
      nxt_status[ST_CPLOW]   = range_low;
      nxt_status[ST_CPHIGH]  = range_high;
   end

   // sampled every cycle, so a read sees the state one cycle old;
   // reads never write it back, so polling cannot disturb calibration
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         status_ff <= RST_STATUS;
      else
         status_ff <= nxt_status;
   end

   // ==========================================================
   // configuration registers
   // each field has its own flop, so reserved bits never hold state

   // loop filter a; plain storage, the analog filter reads it directly
   // and a write takes effect on the next cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         loop_filter_a_ff <= RST_LOOP_A;
      else if (wr_loop_a)
         loop_filter_a_ff <= reg_wr_data;
   end

   // loop filter b, whole byte writable
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         loop_filter_b_ff <= RST_LOOP_B;
      else if (wr_loop_b)
         loop_filter_b_ff <= reg_wr_data;
   end

   // loop filter c, whole byte writable
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         loop_filter_c_ff <= RST_LOOP_C;
      else if (wr_loop_c)
         loop_filter_c_ff <= reg_wr_data;
   end

   // pump current setting, all ones out of reset;
   // bit 7 of this register has no flop and reads zero
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pump_current_setting_ff <= RST_PUMP[PUMP_CUR_MSB:0];
      else if (wr_pump)
         pump_current_setting_ff <= reg_wr_data[PUMP_CUR_MSB:0];
   end

   // logic generator power mode, mode 0 out of reset
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         logic_generator_power_mode_ff <= RST_PUMP[PUMP_MODE];
      else if (wr_pump)
         logic_generator_power_mode_ff <= reg_wr_data[PUMP_MODE];
   end

   // regulator reference source: 0 band gap, 1 half-supply divider;
   // the switch follows the write with no settling delay of its own
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         regulator_reference_select_ff <= RST_REFDIV[REF_SEL];
      else if (wr_refdiv)
         regulator_reference_select_ff <= reg_wr_data[REF_SEL];
   end

   // reference filter bypass; comes out of reset bypassed
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         regulator_filter_bypass_ff <= RST_REFDIV[REF_BYPASS];
      else if (wr_refdiv)
         regulator_filter_bypass_ff <= reg_wr_data[REF_BYPASS];
   end

   // input oversampling code; code 3 has no defined meaning and is
   // simply kept as written, software must not rely on it
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         input_oversample_select_ff <= RST_REFDIV[OVS_MSB:0];
      else if (wr_refdiv)
         input_oversample_select_ff <= reg_wr_data[OVS_MSB:0];
   end

   // ==========================================================
   // read path
   // one-cycle latency from strobe to valid; reads never stall

   // register images as the bus sees them, reserved bits zero
   wire [7:0] img_pump   = {1'b0, logic_generator_power_mode_ff, pump_current_setting_ff};
   wire [7:0] img_refdiv = {4'h0, regulator_reference_select_ff,
                            regulator_filter_bypass_ff, input_oversample_select_ff};

   logic [7:0] rd_mux;

   // unmapped addresses read zero; a read and a write in one cycle
   // return the value held before the write
   always_comb
   begin
      rd_mux = 8'h00;
      if (sel_status)
         rd_mux = status_ff;
      else if (sel_loop_a)
         rd_mux = loop_filter_a_ff;
      else if (sel_loop_b)
         rd_mux = loop_filter_b_ff;
      else if (sel_loop_c)
         rd_mux = loop_filter_c_ff;
      else if (sel_pump)
         rd_mux = img_pump;
      else if (sel_refdiv)
         rd_mux = img_refdiv;
      else
         rd_mux = 8'h00;
   end

   // read valid, one cycle after the strobe
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rd_valid_ff <= 1'b0;
      else
         reg_rd_valid_ff <= reg_rd_en;
   end

   // read data, held until the next read
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rd_data_ff <= 8'h00;
      else if (reg_rd_en)
         reg_rd_data_ff <= rd_mux;
   end

   // lock flag mirrored out for the rest of the receiver; it changes
   // in the same cycle as status bit 0, both being copies of one flop
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         synth_locked_flag_ff <= 1'b0;
      else
         synth_locked_flag_ff <= lock_flag;
   end

endmodule
`default_nettype wire

// ===== hw/sps_sequencer.sv
// power-up sequencer: currents on, then an automatic calibration start
`default_nettype none
module sps_sequencer
   import sps_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic synth_enable,
   input  wire logic recal_request,
   input  wire logic bias_ready,
   output logic      currents_on_ff,
   output logic      cal_start_ff
);

   sps_seq_e state_ff;
   sps_seq_e nxt_state;
   logic     recal_d_ff;
   wire      recal_rise = recal_request && !recal_d_ff;

   // next state: power up, wait for bias, fire one calibration start
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         SPS_IDLE:  if (synth_enable) nxt_state = SPS_POWER;
         SPS_POWER: if (!synth_enable) nxt_state = SPS_IDLE;
                    else if (bias_ready) nxt_state = SPS_CAL;
         SPS_CAL:   nxt_state = synth_enable ? SPS_RUN : SPS_IDLE;
         SPS_RUN:   if (!synth_enable) nxt_state = SPS_IDLE;
                    else if (recal_rise) nxt_state = SPS_CAL;
         default:   nxt_state = SPS_IDLE;
      endcase
   end

   // state and output registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff       <= SPS_IDLE;
         recal_d_ff     <= 1'b0;
         currents_on_ff <= 1'b0;
         cal_start_ff   <= 1'b0;
      end
      else
      begin
         state_ff       <= nxt_state;
         recal_d_ff     <= recal_request;
         currents_on_ff <= (nxt_state != SPS_IDLE);
         cal_start_ff   <= (nxt_state == SPS_CAL);
      end
   end

endmodule
`default_nettype wire

// ===== test/sps_regs_monitor.sv
// concurrent checks on the ports of the pll status and configuration bank
`default_nettype none
module sps_regs_monitor
   import sps_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [11:0] reg_addr,
   input wire logic        reg_wr_en,
   input wire logic [7:0]  reg_wr_data,
   input wire logic        reg_rd_en,
   input wire logic [7:0]  reg_rd_data_ff,
   input wire logic        reg_rd_valid_ff,
   input wire logic        synth_enable,
   input wire logic [3:0]  oscillator_output_level,
   input wire logic        pll_lock_raw,
   input wire logic        bias_currents_ready,
   input wire logic        oscillator_calibration_running,
   input wire logic        pump_calibration_valid,
   input wire logic        pump_above_high_threshold,
   input wire logic        pump_below_low_threshold,
   input wire logic [7:0]  loop_filter_b_ff,
   input wire logic [5:0]  pump_current_setting_ff,
   input wire logic        logic_generator_power_mode_ff,
   input wire logic        regulator_reference_select_ff,
   input wire logic        regulator_filter_bypass_ff,
   input wire logic [1:0]  input_oversample_select_ff,
   input wire logic        synth_locked_flag_ff,
   input wire logic        pll_currents_on_ff,
   input wire logic        pll_cal_start_ff
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // status read taken in this cycle
   wire st_rd = reg_rd_en && reg_addr == OFS_STATUS;
   // ==========================================================
   // lock flag
   a_lock_needs_raw: assert property (
      $rose(synth_locked_flag_ff) |-> $past(pll_lock_raw, 2) && $past(synth_enable, 2))
      else $error("lock flag rose without raw lock");
   a_lock_drops: assert property (
      !pll_lock_raw [*3] |-> !synth_locked_flag_ff)
      else $error("lock flag held after raw lock fell");
   // ==========================================================
   // status image read back
   a_osc_cal_bit: assert property (
      st_rd |=> reg_rd_data_ff[ST_VCOCAL] == $past(oscillator_calibration_running, 2))
      else $error("calibration running bit wrong");
   a_pump_valid_bit: assert property (
      st_rd |=> reg_rd_data_ff[ST_CPVALID] == $past(pump_calibration_valid, 2))
      else $error("pump valid bit wrong");
   a_pump_high_bit: assert property (
      st_rd && $stable(oscillator_output_level) |=> reg_rd_data_ff[ST_CPHIGH] ==
      ($past(oscillator_output_level, 2) == 4'h0 && $past(pump_above_high_threshold, 2)))
      else $error("pump high bit wrong");
   a_pump_low_bit: assert property (
      st_rd && $stable(oscillator_output_level) |=> reg_rd_data_ff[ST_CPLOW] ==
      ($past(oscillator_output_level, 2) == 4'h0 && $past(pump_below_low_threshold, 2)))
      else $error("pump low bit wrong");
   a_bias_bit: assert property (
      st_rd |=> reg_rd_data_ff[ST_BIAS] == $past(bias_currents_ready, 2))
      else $error("bias ready bit wrong");
   a_reserved_zero: assert property (
      st_rd |=> reg_rd_data_ff[7:6] == 2'h0 && reg_rd_valid_ff)
      else $error("status reserved bits not zero");
   // ==========================================================
   // settings writes
   a_loop_write: assert property (
      reg_wr_en && reg_addr == OFS_LOOP_B |=> loop_filter_b_ff == $past(reg_wr_data))
      else $error("loop filter write lost");
   a_pump_write: assert property (
      reg_wr_en && reg_addr == OFS_PUMP |=>
      {logic_generator_power_mode_ff, pump_current_setting_ff} == $past(reg_wr_data[6:0]))
      else $error("pump register write lost");
   a_regulator_write: assert property (
      reg_wr_en && reg_addr == OFS_REFDIV |=> {regulator_reference_select_ff,
      regulator_filter_bypass_ff, input_oversample_select_ff} == $past(reg_wr_data[3:0]))
      else $error("regulator register write lost");
   // ==========================================================
   // power-up sequencing
   a_currents_on: assert property (
      $rose(synth_enable) |=> pll_currents_on_ff)
      else $error("currents not on after enable");
   a_cal_after_on: assert property (
      pll_cal_start_ff |-> $past(pll_currents_on_ff) ##1 !pll_cal_start_ff)
      else $error("calibration start without currents");
endmodule
bind sps_regs sps_regs_monitor sps_regs_monitor_i (.*);
`default_nettype wire

// ===== test/sps_regs_tb.sv
// self-checking bench for the pll status and configuration register bank
`default_nettype none
module sps_regs_tb
   import sps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_n, reg_wr_en, reg_rd_en, reg_rd_valid_ff, synth_enable;
   logic        recal_request, pll_lock_raw, bias_currents_ready, pump_calibration_valid;
   logic        oscillator_calibration_running, pump_above_high_threshold;
   logic        pump_below_low_threshold, logic_generator_power_mode_ff;
   logic        regulator_reference_select_ff, regulator_filter_bypass_ff;
   logic        synth_locked_flag_ff, pll_currents_on_ff, pll_cal_start_ff;
   logic [11:0] reg_addr;
   logic [15:0] lock_detect_count;
   logic [7:0]  reg_wr_data, reg_rd_data_ff, loop_filter_a_ff, loop_filter_b_ff;
   logic [7:0]  loop_filter_c_ff;
   logic [5:0]  pump_current_setting_ff;
   logic [3:0]  oscillator_output_level;
   logic [1:0]  input_oversample_select_ff;
   logic [7:0]  exp_q[$];
   logic [11:0] adr_q[$];
   int          err_total = 0;
   int          compares = 0;
   logic [31:0] seed = 32'h0000000c;
   logic [11:0] adr_t[5] = '{OFS_LOOP_A, OFS_LOOP_B, OFS_LOOP_C, OFS_PUMP, OFS_REFDIV};
   logic [7:0]  rst_t[5] = '{8'h77, 8'h87, 8'h08, 8'h3f, 8'h04};
   logic [7:0]  msk_t[5] = '{8'hff, 8'hff, 8'hff, 8'h7f, 8'h0f};

   sps_regs sps_regs_i (.*);

   // ==========================================================
   // clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ==========================================================
   // helpers
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [7:0] port_img(input int k);
      case (k)
         0: return loop_filter_a_ff;
         1: return loop_filter_b_ff;
         2: return loop_filter_c_ff;
         3: return {1'b0, logic_generator_power_mode_ff, pump_current_setting_ff};
         default: return {4'h0, regulator_reference_select_ff, regulator_filter_bypass_ff,
                          input_oversample_select_ff};
      endcase
   endfunction
   task automatic stop_test();
      if (err_total == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e)
      begin
         err_total++;
         $display("FAIL %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wr_data <= d;
      reg_wr_en <= 1'b1;
      @(posedge clk);
      reg_wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd_en <= 1'b1;
      exp_q.push_back(e);
      adr_q.push_back(a);
      @(posedge clk);
      reg_rd_en <= 1'b0;
   endtask
   task automatic wait_on(input int s);
      for (int n = 0; n < 40; n++)
      begin
         @(negedge clk);
         if ((s == 0 && pll_currents_on_ff === 1'b1) || (s == 1 && pll_cal_start_ff === 1'b1)
             || (s == 2 && synth_locked_flag_ff === 1'b1))
            return;
      end
      chk($sformatf("wait %0d", s), 8'h01, 8'h00);
      stop_test();
   endtask

   // ==========================================================
   // read watcher: oldest note against each answer
   always @(negedge clk)
      if (reg_rd_valid_ff !== 1'b0)
      begin
         if (exp_q.size() == 0)
            chk("rd_valid", 8'h00, {7'h00, reg_rd_valid_ff});
         else
            chk($sformatf("rd %h", adr_q.pop_front()), exp_q.pop_front(), reg_rd_data_ff);
      end

   // ==========================================================
   // stimulus
   initial
   begin
      logic [31:0] r;
      logic [7:0]  e;
      {reg_wr_en, reg_rd_en, synth_enable, recal_request, pll_lock_raw} <= 5'h00;
      {bias_currents_ready, oscillator_calibration_running, pump_calibration_valid,
       pump_above_high_threshold, pump_below_low_threshold} <= 5'h00;
      {rst_n, reg_addr, reg_wr_data, oscillator_output_level} <= 25'h0;
      lock_detect_count <= 16'h0008;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      for (int k = 0; k < 5; k++)
      begin
         @(negedge clk);
         chk("reset port", rst_t[k], port_img(k));
         rd(adr_t[k], rst_t[k]);
      end
      wr(OFS_STATUS, 8'hff);
      wr(12'h288, 8'h5a);
      rd(OFS_STATUS, 8'h00);
      rd(12'h288, 8'h00);
      for (int j = 0; j < 4; j++)
         for (int k = 0; k < 5; k++)
         begin
            e = 8'(xs());
            wr(adr_t[k], e);
            @(negedge clk);
            chk("written port", e & msk_t[k], port_img(k));
            rd(adr_t[k], e & msk_t[k]);
         end
      for (int c = 0; c < 3; c++)
      begin
         wr(OFS_REFDIV, 8'(c));
         @(negedge clk);
         chk("oversample", 8'(c), {6'h00, input_oversample_select_ff});
      end
      for (int i = 0; i < 12; i++)
      begin
         r = xs();
         @(posedge clk);
         {pump_above_high_threshold, pump_below_low_threshold, pump_calibration_valid,
          oscillator_calibration_running, bias_currents_ready} <= r[4:0];
         oscillator_output_level <= (i < 8) ? 4'h0 : r[11:8];
         repeat (2) @(posedge clk);
         e = {2'b00, r[4:3] & {2{i < 8 || r[11:8] == 4'h0}}, r[2:0], 1'b0};
         rd(OFS_STATUS, e);
         rd(OFS_STATUS, e);
      end
      @(posedge clk);
      {pump_above_high_threshold, pump_below_low_threshold, pump_calibration_valid,
       oscillator_calibration_running, bias_currents_ready} <= 5'h00;
      synth_enable <= 1'b1;
      wait_on(0);
      chk("early cal", 8'h00, {7'h00, pll_cal_start_ff});
      @(posedge clk);
      bias_currents_ready <= 1'b1;
      wait_on(1);
      @(posedge clk);
      pll_lock_raw <= 1'b1;
      repeat (5) @(negedge clk);
      chk("early lock", 8'h00, {7'h00, synth_locked_flag_ff});
      wait_on(2);
      repeat (2) @(posedge clk);
      rd(OFS_STATUS, 8'h03);
      recal_request <= 1'b1;
      wait_on(1);
      @(posedge clk);
      pll_lock_raw <= 1'b0;
      repeat (4) @(posedge clk);
      rd(OFS_STATUS, 8'h02);
      synth_enable <= 1'b0;
      repeat (3) @(negedge clk);
      chk("currents", 8'h00, {7'h00, pll_currents_on_ff});
      repeat (4) @(posedge clk);
      chk("pending reads", 8'h00, 8'(exp_q.size()));
      stop_test();
   end
endmodule
`default_nettype wire
